// ==== hw/pmsc_pkg.sv ====
// constants and types for the phy management status and control slice
// assumes one 200 MHz clock; the management bus pins arrive unsynchronised
package pmsc_pkg;

    // register addresses on the management bus
    localparam logic [4:0]  REG_PARTNER_NP  = 5'h08;
    localparam logic [4:0]  REG_RX_PREAMBLE = 5'h14;
    localparam logic [4:0]  REG_SYMERR_CNT  = 5'h15;
    localparam logic [4:0]  REG_EVENT       = 5'h1B;

    // preamble control layout
    localparam int          POS_RESTORE100  = 7;
    localparam int          POS_RESTORE10   = 6;
    localparam logic [15:0] PREAMBLE_FIXED  = 16'h0001;
    localparam logic [2:0]  STRAP_RESTORE   = 3'h4;
    localparam logic [1:0]  STRAP_SETTLE    = 2'h3;

    // event register layout
    localparam int          EVT_EN_LSB      = 8;
    localparam logic [15:0] CNT_MAX         = 16'hFFFF;
    localparam logic [15:0] CNT_ONE         = 16'h0001;
    localparam logic [7:0]  SFD_BYTE        = 8'hD5;

    // management frame figures
    localparam logic [1:0]  OP_READ         = 2'h2;
    localparam logic [1:0]  OP_WRITE        = 2'h1;
    localparam logic [5:0]  PREAMBLE_ONES   = 6'h20;
    localparam logic [4:0]  OP_LAST         = 5'h01;
    localparam logic [4:0]  ADDR_LAST       = 5'h09;
    localparam logic [4:0]  TURN_LAST       = 5'h01;
    localparam logic [4:0]  DATA_LAST       = 5'h0F;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } pmsc_rx_byte_t;

    // bit order matches the flag field, link up in bit 0
    typedef struct packed {
        logic jabber;
        logic rxError;
        logic pageRx;
        logic parDetFault;
        logic lpAck;
        logic linkDown;
        logic remoteFault;
        logic linkUp;
    } pmsc_evt_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_START,
        S_OP,
        S_ADDR,
        S_TURN,
        S_DATA
    } pmsc_state_t;

endpackage : pmsc_pkg

// ==== hw/pmsc_sync.sv ====
// three-stage synchroniser for one pin
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module pmsc_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic pinIn,
    output var  logic pinOut
);
    logic stage1_q;
    logic stage2_q;
    logic stage3_q;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            stage1_q <= RESET_VAL;
            stage2_q <= RESET_VAL;
            stage3_q <= RESET_VAL;
        end else begin
            stage1_q <= pinIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // accept a change only once two stages agree
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pinOut <= RESET_VAL;
        end else if (stage2_q == stage3_q) begin
            pinOut <= stage3_q;
        end
    end
endmodule : pmsc_sync
`default_nettype wire

// ==== hw/pmsc_regs.sv ====
// management register slice: partner next page, preamble control,
// symbol-error counter, event enables and flags, behind a serial
// management slave; also the receive preamble trimming path
// assumes events and receive bytes come from logic on ref_clk
`timescale 1ns/100ps
`default_nettype none
module pmsc_regs
    import pmsc_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input  wire logic          ref_clk,
    input  wire logic          reset_n,
    input  wire logic          mdc,
    input  wire logic          mdioIn,
    output var  logic          mdioOut,
    output var  logic          mdioOe,
    input  wire logic [2:0]    strapConfig,
    input  wire logic [15:0]   partnerPageWord,
    input  wire logic          partnerPageLoad,
    input  wire logic          symErrFrame,
    input  wire pmsc_evt_t     events,
    input  wire logic          speed100,
    input  wire pmsc_rx_byte_t rxIn,
    output var  pmsc_rx_byte_t rxOut,
    output var  logic          intrActive
);
    logic              mdcS;
    logic              mdioS;
    logic [2:0]        strapS;
    logic              mdcPrev_q;
    logic              mdcRise;
    pmsc_state_t       state_q;
    logic [4:0]        bitCnt_q;
    logic [5:0]        ones_q;
    logic [1:0]        opcode_q;
    logic [9:0]        addr_q;
    logic [15:0]       shift_q;
    logic              isRead_q;
    logic              hit_q;
    logic [9:0]        nextAddr;
    logic [1:0]        nextOp;
    logic              readStrobe;
    logic              writeStrobe;
    logic [15:0]       wrData;
    logic [15:0]       rdData;
    logic [15:0]       partnerNp_q;
    logic              restore100_q;
    logic              restore10_q;
    logic [1:0]        strapWait_q;
    logic              strapDone_q;
    logic [15:0]       symErrCnt_q;
    logic [7:0]        flags_q;
    logic [7:0]        enables_q;
    logic              rxValidPrev_q;
    logic              hunting_q;
    logic              rxFirst;
    logic              rxKeep;
    // pins from the station side
    pmsc_sync #(.RESET_VAL(1'b0)) u_syncMdc (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .pinIn   (mdc),
        .pinOut  (mdcS)
    );
    // bus idles high through its pull-up
    pmsc_sync #(.RESET_VAL(1'b1)) u_syncMdio (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .pinIn   (mdioIn),
        .pinOut  (mdioS)
    );
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_strap
            pmsc_sync #(.RESET_VAL(1'b0)) u_syncStrap (
                .ref_clk (ref_clk),
                .reset_n (reset_n),
                .pinIn   (strapConfig[gi]),
                .pinOut  (strapS[gi])
            );
        end
    endgenerate
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mdcPrev_q <= 1'b0;
        end else begin
            mdcPrev_q <= mdcS;
        end
    end
    assign mdcRise = mdcS & ~mdcPrev_q;
    assign nextAddr = {addr_q[8:0], mdioS};
    assign nextOp = {opcode_q[0], mdioS};
    // last address bit of a read aimed at us
    assign readStrobe = mdcRise && (state_q == S_ADDR)
                        && (bitCnt_q == ADDR_LAST)
                        && (opcode_q == OP_READ)
                        && (nextAddr[9:5] == PHY_ADDR);
    assign writeStrobe = mdcRise && (state_q == S_DATA)
                         && (bitCnt_q == DATA_LAST)
                         && !isRead_q && hit_q;
    assign wrData = {shift_q[14:0], mdioS};
    // read data for the addressed register
    always_comb begin
        rdData = 16'h0000;
        case (nextAddr[4:0])
            REG_PARTNER_NP: begin
                rdData = partnerNp_q;
            end
            REG_RX_PREAMBLE: begin
                rdData = PREAMBLE_FIXED;
                rdData[POS_RESTORE100] = restore100_q;
                rdData[POS_RESTORE10] = restore10_q;
            end
            REG_SYMERR_CNT: begin
                rdData = symErrCnt_q;
            end
            REG_EVENT: begin
                rdData = {enables_q, flags_q};
            end
            default: begin
                rdData = 16'h0000;
            end
        endcase
    end
    // frame walker, one step per rising mdc
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_q  <= S_IDLE;
            bitCnt_q <= 5'h00;
            ones_q   <= 6'h00;
            opcode_q <= 2'h0;
            addr_q   <= 10'h000;
            shift_q  <= 16'h0000;
            isRead_q <= 1'b0;
            hit_q    <= 1'b0;
        end else if (mdcRise) begin
            case (state_q)
                S_IDLE: begin
                    // need a full run of ones before a start
                    if (mdioS) begin
                        if (ones_q != PREAMBLE_ONES) begin
                            ones_q <= ones_q + 6'h01;
                        end
                    end else begin
                        if (ones_q == PREAMBLE_ONES) begin
                            state_q <= S_START;
                        end
                        ones_q <= 6'h00;
                    end
                end
                S_START: begin
                    state_q  <= mdioS ? S_OP : S_IDLE;
                    bitCnt_q <= 5'h00;
                end
                S_OP: begin
                    opcode_q <= nextOp;
                    if (bitCnt_q == OP_LAST) begin
                        bitCnt_q <= 5'h00;
                        if (nextOp == OP_READ || nextOp == OP_WRITE) begin
                            state_q <= S_ADDR;
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end else begin
                        bitCnt_q <= bitCnt_q + 5'h01;
                    end
                end
                S_ADDR: begin
                    addr_q <= nextAddr;
                    if (bitCnt_q == ADDR_LAST) begin
                        state_q  <= S_TURN;
                        bitCnt_q <= 5'h00;
                        isRead_q <= (opcode_q == OP_READ);
                        hit_q    <= (nextAddr[9:5] == PHY_ADDR);
                        if (readStrobe) begin
                            shift_q <= rdData;
                        end
                    end else begin
                        bitCnt_q <= bitCnt_q + 5'h01;
                    end
                end
                S_TURN: begin
                    if (bitCnt_q == TURN_LAST) begin
                        state_q  <= S_DATA;
                        bitCnt_q <= 5'h00;
                        if (isRead_q) begin
                            shift_q <= {shift_q[14:0], 1'b0};
                        end
                    end else begin
                        bitCnt_q <= bitCnt_q + 5'h01;
                    end
                end
                S_DATA: begin
                    if (isRead_q) begin
                        shift_q <= {shift_q[14:0], 1'b0};
                    end else begin
                        shift_q <= wrData;
                    end
                    if (bitCnt_q == DATA_LAST) begin
                        state_q <= S_IDLE;
                    end else begin
                        bitCnt_q <= bitCnt_q + 5'h01;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
    // pin driver: zero in second turnaround bit, then data msb first
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mdioOut <= 1'b0;
            mdioOe  <= 1'b0;
        end else if (mdcRise && isRead_q && hit_q) begin
            case (state_q)
                S_TURN: begin
                    if (bitCnt_q == TURN_LAST) begin
                        mdioOut <= shift_q[15];
                    end else begin
                        mdioOe  <= 1'b1;
                        mdioOut <= 1'b0;
                    end
                end
                S_DATA: begin
                    if (bitCnt_q == DATA_LAST) begin
                        mdioOe  <= 1'b0;
                        mdioOut <= 1'b0;
                    end else begin
                        mdioOut <= shift_q[15];
                    end
                end
                default: begin
                    mdioOe <= 1'b0;
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            partnerNp_q <= 16'h0000;
        end else if (partnerPageLoad) begin
            partnerNp_q <= partnerPageWord;
        end
    end
    // straps sampled one edge after done: the synchroniser output lands on the done edge
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            strapWait_q <= 2'h0;
            strapDone_q <= 1'b0;
        end else if (!strapDone_q) begin
            if (strapWait_q == STRAP_SETTLE) begin
                strapDone_q <= 1'b1;
            end else begin
                strapWait_q <= strapWait_q + 2'h1;
            end
        end else if (strapWait_q == STRAP_SETTLE) begin
            strapWait_q <= 2'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            restore100_q <= 1'b0;
        end else if (strapDone_q && strapWait_q == STRAP_SETTLE) begin
            restore100_q <= (strapS == STRAP_RESTORE);
        end else if (writeStrobe && addr_q[4:0] == REG_RX_PREAMBLE) begin
            restore100_q <= wrData[POS_RESTORE100];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            restore10_q <= 1'b0;
        end else if (writeStrobe && addr_q[4:0] == REG_RX_PREAMBLE) begin
            restore10_q <= wrData[POS_RESTORE10];
        end
    end

    // count with clear on read
    // a frame landing on the clearing read still counts
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            symErrCnt_q <= 16'h0000;
        end else if (readStrobe && nextAddr[4:0] == REG_SYMERR_CNT) begin
            symErrCnt_q <= symErrFrame ? CNT_ONE : 16'h0000;
        end else if (symErrFrame && symErrCnt_q != CNT_MAX) begin
            symErrCnt_q <= symErrCnt_q + CNT_ONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            enables_q <= 8'h00;
        end else if (writeStrobe && addr_q[4:0] == REG_EVENT) begin
            enables_q <= wrData[EVT_EN_LSB +: 8];
        end
    end

    // sticky flags, set beats read clear
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            flags_q <= 8'h00;
        end else if (readStrobe && nextAddr[4:0] == REG_EVENT) begin
            flags_q <= events;
        end else begin
            flags_q <= flags_q | events;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            intrActive <= 1'b0;
        end else begin
            intrActive <= |(flags_q & enables_q);
        end
    end

    // receive preamble trimming
    assign rxFirst = rxIn.valid & ~rxValidPrev_q;

    always_comb begin
        rxKeep = 1'b0;
        if (!rxIn.valid) begin
            rxKeep = 1'b0;
        end else if (speed100) begin
            rxKeep = restore100_q | ~rxFirst;
        end else begin
            rxKeep = restore10_q | (rxIn.data == SFD_BYTE)
                     | ~(rxFirst | hunting_q);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rxValidPrev_q <= 1'b0;
            hunting_q     <= 1'b0;
        end else begin
            rxValidPrev_q <= rxIn.valid;
            hunting_q     <= rxIn.valid & (rxFirst | hunting_q)
                             & (rxIn.data != SFD_BYTE);
        end
    end

    // fixed one-cycle latency through the output stage
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rxOut <= '0;
        end else begin
            rxOut.valid <= rxKeep;
            rxOut.data  <= rxIn.data;
        end
    end

endmodule : pmsc_regs
`default_nettype wire

// ==== bench/pmsc_regs_assertions.sv ====
// port checker for the management register slice
// assumes the bench runs mdc at ten ref_clk cycles a half period
`timescale 1ns/100ps
`default_nettype none
module pmsc_regs_assertions
    import pmsc_pkg::*;
(
    input wire logic          ref_clk,
    input wire logic          reset_n,
    input wire logic          mdc,
    input wire logic          mdioOut,
    input wire logic          mdioOe,
    input wire pmsc_evt_t     events,
    input wire pmsc_rx_byte_t rxIn,
    input wire pmsc_rx_byte_t rxOut,
    input wire logic          intrActive
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [5:0] idleCnt_q;
    logic [9:0] oeCnt_q;
    // quiet time since mdc was last high, saturating
    always_ff @(posedge ref_clk) begin
        if (!reset_n || mdc) idleCnt_q <= 6'h00;
        else if (idleCnt_q != 6'h3F) idleCnt_q <= idleCnt_q + 6'h01;
    end
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !mdioOe) oeCnt_q <= 10'h000;
        else oeCnt_q <= oeCnt_q + 10'h001;
    end
    AST_RST_QUIET: assert property ($rose(reset_n) |-> !intrActive && !mdioOe)
        else $error("outputs active after reset");
    AST_RX_COPY: assert property (rxOut.valid |-> $past(rxIn.valid) && rxOut.data == $past(rxIn.data))
        else $error("kept byte differs from input");
    AST_RX_GAP: assert property (!$past(rxIn.valid) |-> !rxOut.valid)
        else $error("byte out of an idle cycle");
    AST_INTR_HOLD: assert property (idleCnt_q > 6'h28 && $past(events) == 8'h00 && $past(events, 2) == 8'h00
        |-> $stable(intrActive))
        else $error("interrupt moved with no cause");
    AST_INTR_RISE: assert property ($rose(intrActive) |-> $past(events, 2) != 8'h00 || idleCnt_q < 6'h28)
        else $error("interrupt rose without event");
    AST_INTR_FALL: assert property ($fell(intrActive) |-> idleCnt_q < 6'h28)
        else $error("interrupt fell outside access");
    AST_OE_FIRST: assert property ($rose(mdioOe) |-> !mdioOut)
        else $error("turnaround bit not zero");
    AST_OE_SPAN: assert property ($fell(mdioOe) |-> oeCnt_q >= 10'h14A && oeCnt_q <= 10'h15E)
        else $error("read drive length wrong");
endmodule : pmsc_regs_assertions
`default_nettype wire

// ==== bench/pmsc_mdio_master.sv ====
// station manager model driving mdc and the mdio wire
// assumes ref_clk runs; mdc stands low between frames
`timescale 1ns/100ps
`default_nettype none
module pmsc_mdio_master
    import pmsc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic mdioOut,
    input  wire logic mdioOe,
    output var  logic mdc,
    output var  logic mdioIn
);
    logic drv;
    logic bitVal;
    initial begin
        mdc = 1'b0;
        drv = 1'b0;
        bitVal = 1'b1;
    end
    // released wire rests at the pull-up level
    always_comb mdioIn = mdioOe ? mdioOut : (drv ? bitVal : 1'b1);
    task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rdat);
        logic [63:0] f;
        f = {32'hFFFFFFFF, 2'b01, rd ? OP_READ : OP_WRITE, pa, ra, 2'b10, wd};
        rdat = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            drv = !(rd && i < 18);
            bitVal = f[i];
            repeat (10) @(negedge ref_clk);
            // sample late: the device bit stands until the next rise
            if (i < 16) rdat[i] = mdioIn;
            mdc = 1'b1;
            repeat (10) @(negedge ref_clk);
            mdc = 1'b0;
        end
        drv = 1'b0;
        // let an edge pass so a following call never re-drives in this step
        @(negedge ref_clk);
    endtask : xfer
endmodule : pmsc_mdio_master
`default_nettype wire

// ==== bench/phy_mgmt_status_control_regs_tb.sv ====
// self-checking bench for the management register slice
// assumes the station manager model and the port checker
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_status_control_regs_tb
    import pmsc_pkg::*;
;
    localparam logic [4:0] PHY = 5'h03;
    logic          ref_clk = 1'b0;
    logic          reset_n = 1'b0;
    logic          mdc;
    logic          mdioIn;
    logic          mdioOut;
    logic          mdioOe;
    logic [2:0]    strapConfig = 3'h4;
    logic [15:0]   partnerPageWord = 16'h0000;
    logic          partnerPageLoad = 1'b0;
    logic          symErrFrame = 1'b0;
    pmsc_evt_t     events = 8'h00;
    logic          speed100 = 1'b0;
    pmsc_rx_byte_t rxIn = 9'h000;
    pmsc_rx_byte_t rxOut;
    logic          intrActive;
    int            failures = 0;
    int            comparisons = 0;
    int            cycles = 0;
    logic [31:0]   randState = 32'h3439;
    logic [7:0]    outQ[$];
    logic [7:0]    fr[11];
    logic [15:0]   w;
    logic [15:0]   en;
    int            d;

    pmsc_regs #(.PHY_ADDR(PHY)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .mdc(mdc), .mdioIn(mdioIn),
        .mdioOut(mdioOut), .mdioOe(mdioOe), .strapConfig(strapConfig), .partnerPageWord(partnerPageWord),
        .partnerPageLoad(partnerPageLoad), .symErrFrame(symErrFrame), .events(events),
        .speed100(speed100), .rxIn(rxIn), .rxOut(rxOut), .intrActive(intrActive));
    pmsc_mdio_master mgr (.ref_clk(ref_clk), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdc(mdc),
        .mdioIn(mdioIn));

    always #2.5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (rxOut.valid === 1'b1) outQ.push_back(rxOut.data);
    // cut a hang short well above the expected run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            results();
        end
    end

    function automatic logic [31:0] nextRand();
        randState ^= randState << 13;
        randState ^= randState >> 17;
        randState ^= randState << 5;
        return randState;
    endfunction : nextRand
    function automatic int dropCnt(input logic s, input logic r);
        return r ? 0 : (s ? 1 : 7);
    endfunction : dropCnt
    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task rd(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] v;
        mgr.xfer(1'b1, PHY, ra, 16'h0000, v);
        check(v, exp);
    endtask : rd
    task wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] v;
        mgr.xfer(1'b0, PHY, ra, wd, v);
    endtask : wr
    task rst(input logic [2:0] strap);
        @(negedge ref_clk);
        reset_n = 1'b0;
        strapConfig = strap;
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (10) @(negedge ref_clk);
    endtask : rst
    task pulseEvt(input logic [7:0] e);
        events = e;
        @(negedge ref_clk);
        events = 8'h00;
        repeat (4) @(negedge ref_clk);
    endtask : pulseEvt
    task results();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    initial begin
        rst(3'h4);
        rd(REG_PARTNER_NP, 16'h0000);
        rd(REG_RX_PREAMBLE, 16'h0081);
        rd(REG_SYMERR_CNT, 16'h0000);
        rd(REG_EVENT, 16'h0000);
        // page word loads, writes from the bus are ignored
        for (int k = 0; k < 2; k++) begin
            w = (k == 0) ? 16'hFFFF : 16'(nextRand());
            partnerPageWord = w;
            partnerPageLoad = 1'b1;
            @(negedge ref_clk);
            partnerPageLoad = 1'b0;
            wr(REG_PARTNER_NP, ~w);
            rd(REG_PARTNER_NP, w);
        end
        wr(REG_RX_PREAMBLE, 16'hFFFF);
        rd(REG_RX_PREAMBLE, 16'h00C1);
        for (int m = 0; m < 4; m++) begin
            wr(REG_RX_PREAMBLE, m[1] ? 16'h00C0 : 16'h0000);
            speed100 = m[0];
            outQ.delete();
            for (int k = 0; k < 11; k++) begin
                fr[k] = (k < 7) ? 8'h55 : (k == 7) ? SFD_BYTE : 8'(nextRand());
                rxIn = {1'b1, fr[k]};
                @(negedge ref_clk);
            end
            rxIn = 9'h000;
            repeat (4) @(negedge ref_clk);
            d = dropCnt(m[0], m[1]);
            check(16'(outQ.size()), 16'(11 - d));
            foreach (outQ[j]) check({8'h00, outQ[j]}, {8'h00, fr[j + d]});
        end
        w = {12'h000, 4'(nextRand())} + 16'h0001;
        symErrFrame = 1'b1;
        repeat (w) @(negedge ref_clk);
        symErrFrame = 1'b0;
        // a read at another address must not clear the count
        mgr.xfer(1'b1, PHY + 5'h01, REG_SYMERR_CNT, 16'h0000, en);
        check(en, 16'hFFFF);
        rd(REG_SYMERR_CNT, w);
        rd(REG_SYMERR_CNT, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            en = 16'(16'h0100 << i);
            wr(REG_EVENT, en | 16'h00FF);
            pulseEvt(~en[15:8]);
            check({15'h0000, intrActive}, 16'h0000);
            pulseEvt(en[15:8]);
            check({15'h0000, intrActive}, 16'h0001);
            rd(REG_EVENT, en | 16'h00FF);
            check({15'h0000, intrActive}, 16'h0000);
            rd(REG_EVENT, en);
        end
        rst(3'h3);
        rd(REG_RX_PREAMBLE, 16'h0001);
        results();
    end
endmodule : phy_mgmt_status_control_regs_tb

bind pmsc_regs pmsc_regs_assertions u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .mdc(mdc),
    .mdioOut(mdioOut), .mdioOe(mdioOe), .events(events), .rxIn(rxIn), .rxOut(rxOut),
    .intrActive(intrActive));
`default_nettype wire
